// ==== src/serial_in_parallel_out_latch.v ====
`include "sipo_latch_regs.vh"

module serial_in_parallel_out_latch #(
	parameter WIDTH  = `SIPO_WIDTH,
	parameter STAGES = `SIPO_SYNC_STAGES
) (
	input  wire             clk,                // System clock, 200 MHz
	input  wire             rst_n,              // Asynchronous reset, active low
	input  wire             clk_en,             // Freezes all state while low
	input  wire             shift_clock,        // Shift clock pin
	input  wire             storage_clock,      // Storage clock pin
	input  wire             shift_clear_n,      // Shift clear pin, active low
	input  wire             output_enable_n,    // Output enable pin, active low
	input  wire             serial_data_in,     // Serial data pin
	output wire [WIDTH-1:0] parallel_out,       // Open-drain output level, always 0
	output wire [WIDTH-1:0] parallel_out_oe,    // High while the pin sinks
	output reg              cascade_serial_out, // Push-pull cascade output
	output wire             cascade_serial_oe   // Always driven
);


	// Positions of the pins inside the synchroniser and filter vectors.
	localparam PIN_SHIFT_CLOCK   = 0;
	localparam PIN_STORAGE_CLOCK = 1;
	localparam PIN_CLEAR_N       = 2;
	localparam PIN_ENABLE_N      = 3;
	localparam PIN_SERIAL_DATA   = 4;
	localparam NPINS             = 5;

	// Index of the last shift stage, which feeds the cascade output.
	localparam LAST_STAGE = WIDTH - 1;

	// What the shift stages do in one clock cycle.
	localparam [1:0] SHIFT_HOLD  = 2'b00;
	localparam [1:0] SHIFT_CLEAR = 2'b01;
	localparam [1:0] SHIFT_STEP  = 2'b10;

	reg  [NPINS-1:0] sync_chain [0:STAGES-1];
	reg  [NPINS-1:0] pin_state;
	reg  [WIDTH-1:0] shift_reg;
	reg  [WIDTH-1:0] storage_reg;
	reg  [WIDTH-1:0] drive_low;
	reg  [1:0]       shift_action;
	reg  [WIDTH-1:0] next_shift;
	reg  [WIDTH-1:0] next_storage;
	reg  [WIDTH-1:0] next_drive_low;
	reg              next_cascade;
	wire [NPINS-1:0] pins_in;
	wire [NPINS-1:0] sync_second;
	wire [NPINS-1:0] sync_third;
	wire [NPINS-1:0] next_pin_state;
	wire             shift_rise;
	wire             store_rise;
	wire             clear_active;
	wire             outputs_enabled;
	wire             serial_level;
	wire             capture_allowed;
	integer          k;

	// A high level is taken over only once the second and third stages agree; while they differ
	// the level reads low, so a sample caught in a falling pin transition is acted on at once.
	function [NPINS-1:0] filter_levels;
		input [NPINS-1:0] held;
		input [NPINS-1:0] second;
		input [NPINS-1:0] third;
		begin
			filter_levels = (held & ~(second ^ third)) | (second & third);
		end
	endfunction

	// Rising edge of one filtered pin, from its held level to its new one.
	function rose;
		input held;
		input fresh;
		begin
			rose = fresh & ~held;
		end
	endfunction

	// One shift step: stage zero takes the serial level, the rest move on.
	function [WIDTH-1:0] shift_step;
		input [WIDTH-1:0] stages;
		input             level;
		begin
			shift_step = {stages[WIDTH-2:0], level};
		end
	endfunction

	// A stored zero pulls its pin low; a stored one leaves the pin floating.
	function [WIDTH-1:0] sink_mask;
		input [WIDTH-1:0] stored;
		input             enabled;
		begin
			if (enabled) begin
				sink_mask = ~stored;
			end else begin
				sink_mask = {WIDTH{1'b0}};
			end
		end
	endfunction

	assign pins_in[PIN_SHIFT_CLOCK]   = shift_clock;
	assign pins_in[PIN_STORAGE_CLOCK] = storage_clock;
	assign pins_in[PIN_CLEAR_N]       = shift_clear_n;
	assign pins_in[PIN_ENABLE_N]      = output_enable_n;
	assign pins_in[PIN_SERIAL_DATA]   = serial_data_in;

	assign sync_second    = sync_chain[STAGES-2];
	assign sync_third     = sync_chain[STAGES-1];
	assign next_pin_state = filter_levels(pin_state, sync_second, sync_third);

	// Edges are found on the filtered levels, so one pin edge counts once.
	assign shift_rise = rose(pin_state[PIN_SHIFT_CLOCK],
		next_pin_state[PIN_SHIFT_CLOCK]);
	assign store_rise = rose(pin_state[PIN_STORAGE_CLOCK],
		next_pin_state[PIN_STORAGE_CLOCK]);

	assign clear_active    = ~next_pin_state[PIN_CLEAR_N];
	assign outputs_enabled = ~next_pin_state[PIN_ENABLE_N];
	assign serial_level    = next_pin_state[PIN_SERIAL_DATA];
	assign capture_allowed = store_rise & ~clear_active;

	// Only the first stage samples the pins; every later stage reads the one
	// before it. Reset loads the idle levels so that neither a false clock
	// edge nor a stray clear or enable follows the release of reset.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (k = 0; k < STAGES; k = k + 1) begin
				sync_chain[k] <= `SIPO_PIN_IDLE;
			end
		end else if (clk_en) begin
			sync_chain[0] <= pins_in;
			for (k = 1; k < STAGES; k = k + 1) begin
				sync_chain[k] <= sync_chain[k-1];
			end
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_state <= `SIPO_PIN_IDLE;
		end else if (clk_en) begin
			pin_state <= next_pin_state;
		end
	end

	// Clear wins over a coincident shift edge and holds the stages at zero
	// for as long as it stays low.
	always @* begin
		shift_action = SHIFT_HOLD;
		if (clear_active) begin
			shift_action = SHIFT_CLEAR;
		end else if (shift_rise) begin
			shift_action = SHIFT_STEP;
		end
	end

	always @* begin
		case (shift_action)
			SHIFT_CLEAR: begin
				next_shift = `SIPO_CLEAR_VALUE;
			end
			SHIFT_STEP: begin
				next_shift = shift_step(shift_reg, serial_level);
			end
			default: begin
				next_shift = shift_reg;
			end
		endcase
	end

	// The capture reads the stages as they stood before this cycle, so a
	// shift edge in the same cycle is seen only by the next capture.
	always @* begin
		next_storage = storage_reg;
		if (capture_allowed) begin
			next_storage = shift_reg;
		end
	end

	always @* begin
		next_cascade   = next_shift[LAST_STAGE];
		next_drive_low = sink_mask(next_storage, outputs_enabled);
	end

	// Reset stands in for power-up; zero is one legal choice of the undefined
	// start state, so the controller must not rely on it.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg <= `SIPO_CLEAR_VALUE;
		end else if (clk_en) begin
			shift_reg <= next_shift;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			storage_reg <= `SIPO_CLEAR_VALUE;
		end else if (clk_en) begin
			storage_reg <= next_storage;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cascade_serial_out <= 1'b0;
		end else if (clk_en) begin
			cascade_serial_out <= next_cascade;
		end
	end

	// The enable acts only on the pin drivers; both registers keep their
	// contents while the outputs float.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_low <= {WIDTH{1'b0}};
		end else if (clk_en) begin
			drive_low <= next_drive_low;
		end
	end

	assign parallel_out      = {WIDTH{1'b0}};
	assign parallel_out_oe   = drive_low;
	assign cascade_serial_oe = 1'b1;

endmodule

// ==== shared/sipo_latch_regs.vh ====
`ifndef SIPO_LATCH_REGS_VH
`define SIPO_LATCH_REGS_VH
`define SIPO_WIDTH       8
`define SIPO_SYNC_STAGES 3
`define SIPO_MSB_STAGE   7
`define SIPO_CLEAR_VALUE 8'h00
`define SIPO_PIN_IDLE    5'h0c
`define SIPO_LINK_PERIOD_NS 125
`endif

// ==== sim/gpio_host.sv ====
module gpio_host (
	input  logic clk,
	output logic shift_clock = 0,
	output logic storage_clock = 0,
	output logic serial_data_in = 0
);
	timeunit 1ns;
	timeprecision 100ps;
	// Low and high phases of the 125 ns link clock, in system cycles.
	localparam int LOW_CYC = 13;
	localparam int HIGH_CYC = 12;
	task pulse(input logic sh, input logic st);
		repeat (LOW_CYC) @(posedge clk);
		shift_clock <= sh;
		storage_clock <= st;
		repeat (HIGH_CYC) @(posedge clk);
		shift_clock <= 0;
		storage_clock <= 0;
	endtask
	task put(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk);
			serial_data_in <= d[i];
			pulse(1, 0);
		end
	endtask
	task store;
		pulse(0, 1);
	endtask
	task both(input logic b);
		@(posedge clk);
		serial_data_in <= b;
		pulse(1, 1);
	endtask
endmodule

// ==== sim/sipo_checker.sv ====
module sipo_checker (
	input wire logic clk, rst_n, shift_clear_n, output_enable_n,
	input wire logic shift_clock, storage_clock,
	input wire logic cascade_serial_out, cascade_serial_oe,
	input wire logic [7:0] parallel_out, parallel_out_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence clr_held; !shift_clear_n [*5]; endsequence
	sequence shift_quiet; (!shift_clock && shift_clear_n) [*8]; endsequence
	sequence store_quiet; (!storage_clock && !output_enable_n) [*8]; endsequence
	AST_SHIFT_QUIET: assert property (shift_quiet |-> $stable(cascade_serial_out))
		else $error("cascade moved without shift edge");
	AST_STORE_QUIET: assert property (store_quiet |-> $stable(parallel_out_oe))
		else $error("outputs moved without storage edge");
	AST_RESET_FLOAT: assert property ($rose(rst_n) |-> parallel_out_oe == 8'h00)
		else $error("outputs driven after reset");
	AST_SINK_ONLY: assert property (parallel_out == 8'h00) else $error("pin driven high");
	AST_PUSH_PULL: assert property (cascade_serial_oe) else $error("cascade undriven");
	AST_CLEAR: assert property (clr_held |-> !cascade_serial_out) else $error("no clear");
	AST_FLOAT: assert property (output_enable_n [*5] |-> parallel_out_oe == 8'h00)
		else $error("pins not floated");
endmodule
bind serial_in_parallel_out_latch sipo_checker u_chk (.*);

// ==== sim/tb_top.sv ====
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst_n = 0, clr_n = 1, oe_n = 1;
	logic [7:0] d;
	logic b;
	wire [7:0] oe, po;
	wire sck, rck, sd, cso, cso_oe;
	int num_errors = 0, checked = 0;
	gpio_host u_host (.clk(clk), .shift_clock(sck), .storage_clock(rck), .serial_data_in(sd));
	serial_in_parallel_out_latch u_dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
		.shift_clock(sck), .storage_clock(rck), .shift_clear_n(clr_n),
		.output_enable_n(oe_n), .serial_data_in(sd), .parallel_out(po),
		.parallel_out_oe(oe), .cascade_serial_out(cso), .cascade_serial_oe(cso_oe));
	initial forever #2.5 clk = ~clk;
	function automatic logic [7:0] sink(logic [7:0] v); return ~v; endfunction
	function automatic logic [7:0] shifted(logic [7:0] v, logic s); return {v[6:0], s}; endfunction
	task pins(input logic c, input logic e);
		@(posedge clk);
		clr_n <= c;
		oe_n <= e;
	endtask
	task settle;
		repeat (8) @(posedge clk);
		@(negedge clk);
	endtask
	task cmp(input logic [7:0] got, exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task results;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#80000 num_errors++;
		results;
	end
	initial begin
		void'($urandom(32'h6a433bd8));
		repeat (2) @(posedge clk);
		rst_n <= 1;
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'h01 : (i == 1) ? 8'hfe : 8'($urandom);
			u_host.put(d);
			u_host.store;
			pins(1, 0);
			settle;
			cmp(oe, sink(d));
			cmp({7'h00, cso}, {7'h00, d[7]});
			cmp(po, 8'h00);
			cmp({7'h00, cso_oe}, 8'h01);
			pins(1, 1);
			settle;
			cmp(oe, 8'h00);
			pins(1, 0);
			settle;
			cmp(oe, sink(d));
		end
		b = 1'($urandom);
		u_host.both(b);
		settle;
		cmp(oe, sink(d));
		u_host.store;
		settle;
		cmp(oe, sink(shifted(d, b)));
		pins(0, 0);
		settle;
		cmp({7'h00, cso}, 8'h00);
		cmp(oe, sink(shifted(d, b)));
		pins(1, 1);
		u_host.store;
		settle;
		cmp(oe, 8'h00);
		pins(1, 0);
		settle;
		cmp(oe, 8'hff);
		results;
	end
endmodule
